// >>> hbc_pkg.sv
package hbc_pkg;

    // ------------------------------------------------------------------
    // Clock and timer sizing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TMR_W          = 20;

    // ------------------------------------------------------------------
    // Off-time and blanking
    // ------------------------------------------------------------------
    localparam int OFF_INT_US     = 20;
    localparam int OFF_MIN_US     = 10;
    localparam int OFF_MAX_US     = 80;
    localparam int OFF_SET_W      = 8;
    localparam int BLANK_NS       = 2500;
    localparam int BLANK_CYC      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Overcurrent auto-retry
    // ------------------------------------------------------------------
    localparam int RETRY_MS       = 3;
    localparam int RETRY_CYC_DEF  = RETRY_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // Decay selection
    // ------------------------------------------------------------------
    localparam logic [1:0] DECAY_SLOW  = 2'h0;
    localparam logic [1:0] DECAY_MIX30 = 2'h1;
    localparam logic [1:0] DECAY_MIX60 = 2'h2;
    localparam logic [1:0] DECAY_FAST  = 2'h3;
    localparam int FAST_MIX30_PCT = 30;
    localparam int FAST_MIX60_PCT = 60;
    localparam int PCT_FULL       = 100;

    // ------------------------------------------------------------------
    // Trip level table, per mille of full scale
    // ------------------------------------------------------------------
    localparam int LEVEL_W = 10;
    localparam logic [LEVEL_W-1:0] LEVEL_PERMIL [16] = '{
        10'h3E8, 10'h3E0, 10'h3D0, 10'h3B9, 10'h391, 10'h362, 10'h32B, 10'h2E4,
        10'h29D, 10'h24F, 10'h1F8, 10'h199, 10'h133, 10'h0CD, 10'h066, 10'h000
    };

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_OFF     = 4'h2,
        ST_PROTECT = 4'h4,
        ST_SLEEP   = 4'h8
    } mode_e;

    typedef struct packed {
        logic hs_a;
        logic ls_a;
        logic hs_b;
        logic ls_b;
    } gate_s;

    localparam gate_s GATE_HIZ = 4'h0;

    typedef struct packed {
        logic       en;
        logic       dir_a;
        logic       dir_b;
        logic       trip;
        logic       zero;
        logic       overcurrent_guard;
        logic       therm;
        logic       supply_low_lockout;
        logic       sleep_n;
        logic       strap;
        logic [1:0] decay;
        logic [3:0] level;
        logic [OFF_SET_W-1:0] off_us;
    } pin_s;

endpackage

// >>> cycle_timer.sv
`timescale 1ns/100ps
module cycle_timer
    import hbc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic             clear_i,
    input  wire logic [TMR_W-1:0] len_i,
    output logic                  busy_o,
    output logic                  done_o,
    output logic [TMR_W-1:0]      remain_o
);

    logic [TMR_W-1:0] cnt_ff;
    logic             done_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt_ff <= '0;
        end else if (load_i) begin
            cnt_ff <= len_i;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - TMR_W'(1);
        end
    end

    // Pulse in the first cycle the count reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || load_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (cnt_ff == TMR_W'(1));
        end
    end

    assign busy_o   = (cnt_ff != '0);
    assign done_o   = done_ff;
    assign remain_o = cnt_ff;

endmodule // cycle_timer

// >>> hbridge_chopper_control.sv
// Summary of operation
// - Enable low puts both half-bridges in high impedance.
// - Enable high, both directions low: both half-bridges low.
// - Enable high, A high, B low: half-bridge A high, B low.
// - Enable high, A low, B high: half-bridge A low, B high.
// - Enable high, both directions high: both half-bridges high.
// - Slow decay turns on both low-side switches together.
// - Current trip overrides direction inputs and applies decay for off-time.
// - Off-time expiry returns bridge to the commanded state.
// - Current level code selects trip threshold from the fraction table.
// - Strapped off-time pin gives 20 us, else the external setting.
// - Off-time counter covers 10 us to 80 us.
// - Regulation flag pulled low during each loop-imposed off interval.
// - Regulation flag only while the loop forces decay, never input phases.
// - Any direction input transition ends the running off-time.
// - Decay select: slow, 30/70 mixed, 60/40 mixed, fast.
// - Fast decay goes high impedance when current nears zero.
// - Overcurrent counts only after comparator outlasts the deglitch time.
// - Overcurrent: disable, fault low, 3 ms high impedance, then retry.
// - Over-temperature: tri-state and fault low until flag clears.
// - Undervoltage: tri-state and fault low, resume commanded state after.
// - Sleep low tri-states outputs and clears the blanking and retry timers.
`timescale 1ns/100ps
module hbridge_chopper_control
    import hbc_pkg::*;
#(
    parameter int CYCLES_PER_US = CLK_MHZ,
    parameter int RETRY_CYC     = RETRY_CYC_DEF
)(
    input  wire logic                 REF_CLK_I,
    input  wire logic                 RST_I,
    input  wire logic                 SLEEP_N_A_I,
    input  wire logic                 BRIDGE_EN_I,
    input  wire logic                 DIR_IN_A_I,
    input  wire logic                 DIR_IN_B_I,
    input  wire logic [3:0]           CURRENT_LEVEL_CODE_I,
    input  wire logic                 DECAY_SEL_LO_I,
    input  wire logic                 DECAY_SEL_HI_I,
    input  wire logic                 OFFTIME_STRAP_I,
    input  wire logic [OFF_SET_W-1:0] OFFTIME_SET_PIN_I,
    input  wire logic                 CURRENT_TRIP_I,
    input  wire logic                 ZERO_CURRENT_I,
    input  wire logic                 OVERCURRENT_GUARD_I,
    input  wire logic                 THERMAL_CUTOFF_I,
    input  wire logic                 SUPPLY_LOW_LOCKOUT_I,
    output logic                      HS_A_O,
    output logic                      LS_A_O,
    output logic                      HS_B_O,
    output logic                      LS_B_O,
    output logic                      REGULATION_ACTIVE_N_OUT_O,
    output logic                      REGULATION_ACTIVE_N_OE_O,
    output logic                      FAULT_N_OUT_O,
    output logic                      FAULT_N_OE_O,
    output logic [LEVEL_W-1:0]        TRIP_LEVEL_O
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pin_s             pin_raw;
    pin_s             sync1_ff;
    pin_s             sync2_ff;
    logic             dir_a_prev_ff;
    logic             dir_b_prev_ff;
    logic             en_prev_ff;
    mode_e            state_ff;
    mode_e            nxt_state;
    gate_s            gate_ff;
    gate_s            nxt_gate;
    logic             reg_oe_ff;
    logic             fault_oe_ff;
    logic             od_low_ff;
    logic [LEVEL_W-1:0] level_ff;
    logic [TMR_W-1:0] off_len_ff;
    logic [TMR_W-1:0] fast_len_ff;
    logic [1:0]       decay_ff;
    logic             fwd_ff;
    logic             zero_seen_ff;
    logic [TMR_W-1:0] nxt_off_len;
    logic [TMR_W-1:0] nxt_fast_len;
    logic [OFF_SET_W-1:0] off_us;
    logic             dir_change;
    logic             en_rise;
    logic             driving;
    logic             bridge_live;
    logic             hard_fault;
    logic             protect_req;
    logic             go_off;
    logic             off_clear;
    logic             off_done;
    logic [TMR_W-1:0] off_remain;
    logic [TMR_W-1:0] elapsed;
    logic             fast_phase;
    logic             blank_load;
    logic             blank_busy;
    logic             retry_busy;
    logic             deg_load;
    logic             deg_clear;
    logic             deg_busy;
    logic             ocp_event;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Field order follows pin_s
    assign pin_raw = {BRIDGE_EN_I, DIR_IN_A_I, DIR_IN_B_I, CURRENT_TRIP_I, ZERO_CURRENT_I,
                      OVERCURRENT_GUARD_I, THERMAL_CUTOFF_I, SUPPLY_LOW_LOCKOUT_I,
                      SLEEP_N_A_I, OFFTIME_STRAP_I, DECAY_SEL_HI_I, DECAY_SEL_LO_I,
                      CURRENT_LEVEL_CODE_I, OFFTIME_SET_PIN_I};

    // Multi-bit codes are static straps; a skew of one cycle is harmless
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            dir_a_prev_ff <= 1'b0;
            dir_b_prev_ff <= 1'b0;
            en_prev_ff    <= 1'b0;
        end else begin
            dir_a_prev_ff <= sync2_ff.dir_a;
            dir_b_prev_ff <= sync2_ff.dir_b;
            en_prev_ff    <= sync2_ff.en;
        end
    end

    assign dir_change  = (sync2_ff.dir_a != dir_a_prev_ff) || (sync2_ff.dir_b != dir_b_prev_ff);
    assign en_rise     = sync2_ff.en && !en_prev_ff;
    assign driving     = sync2_ff.en && (sync2_ff.dir_a ^ sync2_ff.dir_b);
    assign bridge_live = (state_ff == ST_RUN) || (state_ff == ST_OFF);
    assign hard_fault  = sync2_ff.therm || sync2_ff.supply_low_lockout;
    assign protect_req = ocp_event || hard_fault;

    // ------------------------------------------------------------------
    // Off-time length
    // ------------------------------------------------------------------
    always_comb begin
        off_us = sync2_ff.off_us;
        if (sync2_ff.strap) begin
            off_us = OFF_SET_W'(OFF_INT_US);
        end else if (off_us < OFF_SET_W'(OFF_MIN_US)) begin
            off_us = OFF_SET_W'(OFF_MIN_US);
        end else if (off_us > OFF_SET_W'(OFF_MAX_US)) begin
            off_us = OFF_SET_W'(OFF_MAX_US);
        end
        nxt_off_len = TMR_W'(int'(off_us) * CYCLES_PER_US);
        unique case (sync2_ff.decay)
            DECAY_SLOW:  nxt_fast_len = '0;
            DECAY_MIX30: nxt_fast_len = TMR_W'(int'(nxt_off_len) * FAST_MIX30_PCT / PCT_FULL);
            DECAY_MIX60: nxt_fast_len = TMR_W'(int'(nxt_off_len) * FAST_MIX60_PCT / PCT_FULL);
            DECAY_FAST:  nxt_fast_len = nxt_off_len;
        endcase
    end

    // ------------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (!sync2_ff.sleep_n) begin
            nxt_state = ST_SLEEP;
        end else begin
            unique case (state_ff)
                ST_SLEEP: nxt_state = ST_RUN;
                ST_RUN: begin
                    if (protect_req) begin
                        nxt_state = ST_PROTECT;
                    end else if (driving && sync2_ff.trip && !blank_busy) begin
                        nxt_state = ST_OFF;
                    end
                end
                ST_OFF: begin
                    if (protect_req) begin
                        nxt_state = ST_PROTECT;
                    end else if (off_done || dir_change || !sync2_ff.en) begin
                        nxt_state = ST_RUN;
                    end
                end
                ST_PROTECT: begin
                    if (!hard_fault && !retry_busy && !ocp_event) begin
                        nxt_state = ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            state_ff <= ST_SLEEP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign go_off    = (state_ff != ST_OFF) && (nxt_state == ST_OFF);
    assign off_done  = (off_remain == TMR_W'(1));
    assign off_clear = (state_ff == ST_OFF) && (nxt_state != ST_OFF);

    // ------------------------------------------------------------------
    // Off-phase context captured at the trip
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            off_len_ff  <= '0;
            fast_len_ff <= '0;
            decay_ff    <= DECAY_SLOW;
            fwd_ff      <= 1'b0;
        end else if (go_off) begin
            off_len_ff  <= nxt_off_len;
            fast_len_ff <= nxt_fast_len;
            decay_ff    <= sync2_ff.decay;
            fwd_ff      <= sync2_ff.dir_a;
        end
    end

    assign elapsed    = off_len_ff - off_remain;
    assign fast_phase = (decay_ff == DECAY_FAST) || (elapsed < fast_len_ff);

    // Once the current has collapsed the bridge stays open for the rest of the fast part
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || go_off) begin
            zero_seen_ff <= 1'b0;
        end else if ((state_ff == ST_OFF) && fast_phase && sync2_ff.zero) begin
            zero_seen_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    cycle_timer u_off_timer (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .load_i   (go_off),
        .clear_i  (off_clear),
        .len_i    (nxt_off_len),
        .busy_o   (),
        .done_o   (),
        .remain_o (off_remain)
    );

    // Blanking restarts on every fresh on phase and input edge, except the wake from sleep
    assign blank_load = (nxt_state == ST_RUN)
                        && ((state_ff != ST_RUN) || dir_change || en_rise);

    cycle_timer u_blank_timer (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .load_i   (blank_load),
        .clear_i  (state_ff == ST_SLEEP),
        .len_i    (TMR_W'(BLANK_CYC)),
        .busy_o   (blank_busy),
        .done_o   (),
        .remain_o ()
    );

    // Deglitch only in the run and off states, so a held short re-arms after each retry
    assign deg_load  = sync2_ff.overcurrent_guard && bridge_live && !deg_busy && !ocp_event;
    assign deg_clear = !sync2_ff.overcurrent_guard || !bridge_live;

    cycle_timer u_deglitch_timer (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .load_i   (deg_load),
        .clear_i  (deg_clear),
        .len_i    (TMR_W'(BLANK_CYC)),
        .busy_o   (deg_busy),
        .done_o   (ocp_event),
        .remain_o ()
    );

    cycle_timer u_retry_timer (
        .clk_i    (REF_CLK_I),
        .rst_i    (RST_I),
        .load_i   (ocp_event),
        .clear_i  (state_ff == ST_SLEEP),
        .len_i    (TMR_W'(RETRY_CYC)),
        .busy_o   (retry_busy),
        .done_o   (),
        .remain_o ()
    );

    // ------------------------------------------------------------------
    // Bridge drive
    // ------------------------------------------------------------------
    always_comb begin
        nxt_gate = GATE_HIZ;
        unique case (state_ff)
            ST_RUN: begin
                if (sync2_ff.en) begin
                    nxt_gate.hs_a = sync2_ff.dir_a;
                    nxt_gate.ls_a = !sync2_ff.dir_a;
                    nxt_gate.hs_b = sync2_ff.dir_b;
                    nxt_gate.ls_b = !sync2_ff.dir_b;
                end
            end
            ST_OFF: begin
                if (!fast_phase) begin
                    nxt_gate.ls_a = 1'b1;
                    nxt_gate.ls_b = 1'b1;
                end else if (zero_seen_ff || sync2_ff.zero) begin
                    nxt_gate = GATE_HIZ;
                end else begin
                    nxt_gate.hs_a = !fwd_ff;
                    nxt_gate.ls_a = fwd_ff;
                    nxt_gate.hs_b = fwd_ff;
                    nxt_gate.ls_b = !fwd_ff;
                end
            end
            ST_PROTECT: nxt_gate = GATE_HIZ;
            ST_SLEEP:   nxt_gate = GATE_HIZ;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            gate_ff <= GATE_HIZ;
        end else begin
            gate_ff <= nxt_gate;
        end
    end

    // ------------------------------------------------------------------
    // Status pins and trip level
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            reg_oe_ff   <= 1'b0;
            fault_oe_ff <= 1'b0;
            od_low_ff   <= 1'b0;
        end else begin
            reg_oe_ff   <= (state_ff == ST_OFF);
            fault_oe_ff <= (state_ff == ST_PROTECT);
            od_low_ff   <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            level_ff <= LEVEL_PERMIL[0];
        end else begin
            level_ff <= LEVEL_PERMIL[sync2_ff.level];
        end
    end

    assign HS_A_O                    = gate_ff.hs_a;
    assign LS_A_O                    = gate_ff.ls_a;
    assign HS_B_O                    = gate_ff.hs_b;
    assign LS_B_O                    = gate_ff.ls_b;
    assign REGULATION_ACTIVE_N_OUT_O = od_low_ff;
    assign REGULATION_ACTIVE_N_OE_O  = reg_oe_ff;
    assign FAULT_N_OUT_O             = od_low_ff;
    assign FAULT_N_OE_O              = fault_oe_ff;
    assign TRIP_LEVEL_O              = level_ff;

endmodule // hbridge_chopper_control

// >>> hbc_monitor.sv
`timescale 1ns/100ps
module hbc_monitor
    import hbc_pkg::*;
#(
    parameter int CYCLES_PER_US = CLK_MHZ,
    parameter int RETRY_CYC     = RETRY_CYC_DEF
)(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic SLEEP_N_A_I,
    input wire logic BRIDGE_EN_I,
    input wire logic DIR_IN_A_I,
    input wire logic DIR_IN_B_I,
    input wire logic DECAY_SEL_LO_I,
    input wire logic DECAY_SEL_HI_I,
    input wire logic CURRENT_TRIP_I,
    input wire logic OVERCURRENT_GUARD_I,
    input wire logic THERMAL_CUTOFF_I,
    input wire logic SUPPLY_LOW_LOCKOUT_I,
    input wire logic HS_A_O,
    input wire logic LS_A_O,
    input wire logic HS_B_O,
    input wire logic LS_B_O,
    input wire logic REGULATION_ACTIVE_N_OE_O,
    input wire logic FAULT_N_OE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic [3:0] gates;
    logic       flag_any;
    int         reg_cnt_ff;
    int         ocp_cnt_ff;
    assign gates    = {HS_A_O, LS_A_O, HS_B_O, LS_B_O};
    assign flag_any = THERMAL_CUTOFF_I | SUPPLY_LOW_LOCKOUT_I;
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    // Saturates so a held short cannot wrap the count
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !OVERCURRENT_GUARD_I) ocp_cnt_ff <= 0;
        else if (ocp_cnt_ff < 1000) ocp_cnt_ff <= ocp_cnt_ff + 1;
    end
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !REGULATION_ACTIVE_N_OE_O) reg_cnt_ff <= 0;
        else reg_cnt_ff <= reg_cnt_ff + 1;
    end
    sequence s_steady;
        (BRIDGE_EN_I && SLEEP_N_A_I && !CURRENT_TRIP_I && !OVERCURRENT_GUARD_I && !flag_any
         && $stable(DIR_IN_A_I) && $stable(DIR_IN_B_I))[*6];
    endsequence
    property p_disable; (!BRIDGE_EN_I)[*5] |-> gates == 4'h0; endproperty
    a_disable: assert property (p_disable) else $error("bridge on while disabled");
    property p_table; s_steady |-> FAULT_N_OE_O || REGULATION_ACTIVE_N_OE_O
        || gates == {DIR_IN_A_I, !DIR_IN_A_I, DIR_IN_B_I, !DIR_IN_B_I}; endproperty
    a_table: assert property (p_table) else $error("gates differ from inputs");
    property p_slow; REGULATION_ACTIVE_N_OE_O && BRIDGE_EN_I && !DECAY_SEL_LO_I
        && !DECAY_SEL_HI_I |-> gates == 4'h5; endproperty
    a_slow: assert property (p_slow) else $error("slow decay gates wrong");
    property p_reg_cause; $rose(REGULATION_ACTIVE_N_OE_O) |-> $past(CURRENT_TRIP_I, 4); endproperty
    a_reg_cause: assert property (p_reg_cause) else $error("flag without trip");
    property p_off_max; reg_cnt_ff <= OFF_MAX_US * CYCLES_PER_US; endproperty
    a_off_max: assert property (p_off_max) else $error("off interval too long");
    property p_fault_hiz; FAULT_N_OE_O |-> gates == 4'h0; endproperty
    a_fault_hiz: assert property (p_fault_hiz) else $error("bridge on during fault");
    property p_flag_fault; (SLEEP_N_A_I && flag_any)[*6] |-> FAULT_N_OE_O; endproperty
    a_flag_fault: assert property (p_flag_fault) else $error("flag without fault");
    property p_deglitch; $rose(FAULT_N_OE_O) && !flag_any && !$past(flag_any, 4)
        |-> ocp_cnt_ff >= BLANK_CYC; endproperty
    a_deglitch: assert property (p_deglitch) else $error("short overcurrent taken");
endmodule // hbc_monitor

bind hbridge_chopper_control hbc_monitor #(.CYCLES_PER_US(CYCLES_PER_US),
    .RETRY_CYC(RETRY_CYC)) u_mon (.*);

// >>> mcu_model.sv
`timescale 1ns/100ps
module mcu_model (
    input  wire logic clk_i,
    input  wire logic en_req_i,
    input  wire logic a_req_i,
    input  wire logic b_req_i,
    input  wire logic pwm_i,
    output logic      en_o = 1'b0,
    output logic      a_o  = 1'b0,
    output logic      b_o  = 1'b0
);
    logic [8:0] cnt_ff = 9'h000;
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Enable only follows slow requests; chopping goes on a direction pin
    always @(negedge clk_i) begin
        cnt_ff <= cnt_ff + 9'h001;
        en_o   <= en_req_i;
        a_o    <= a_req_i;
        b_o    <= pwm_i ? cnt_ff[8] : b_req_i;
    end
endmodule // mcu_model

// >>> hbridge_chopper_control_tb_top.sv
`timescale 1ns/100ps
module hbridge_chopper_control_tb_top;
    import hbc_pkg::*;
    localparam int CPU = 100;
    localparam int RETRY = 500;
    localparam int PM[16] = '{1000, 992, 976, 953, 913, 866, 811, 740,
                              669, 591, 504, 409, 307, 205, 102, 0};
    localparam int SET_US[5] = '{0, 10, 80, 5, 200};
    localparam int EXP_US[5] = '{20, 10, 80, 10, 80};
    logic clk = 1'b0, rst = 1'b1, slp_n = 1'b1, en_r = 1'b0, a_r = 1'b0, b_r = 1'b0;
    logic pwm = 1'b0, strap = 1'b1, trip = 1'b0, zero = 1'b0, overcurrent_guard = 1'b0, therm = 1'b0;
    logic supply_low_lockout = 1'b0, dlo = 1'b0, dhi = 1'b0, en, a, b, hs_a, ls_a, hs_b, ls_b, reg_oe, flt_oe;
    logic [3:0] code = 4'h0;
    logic [7:0] set_us = 8'h14;
    logic [9:0] lvl;
    logic [3:0] gates;
    logic [1:0] od_v;
    int         num_errors = 0, tests_run = 0, n;
    assign gates = {hs_a, ls_a, hs_b, ls_b};
    initial begin
        forever #5 clk = ~clk;
    end
    mcu_model u_mcu (.clk_i(clk), .en_req_i(en_r), .a_req_i(a_r), .b_req_i(b_r), .pwm_i(pwm),
                     .en_o(en), .a_o(a), .b_o(b));
    hbridge_chopper_control #(.CYCLES_PER_US(CPU), .RETRY_CYC(RETRY)) DUT (
        .REF_CLK_I(clk), .RST_I(rst), .SLEEP_N_A_I(slp_n), .BRIDGE_EN_I(en), .DIR_IN_A_I(a),
        .DIR_IN_B_I(b), .CURRENT_LEVEL_CODE_I(code), .DECAY_SEL_LO_I(dlo), .DECAY_SEL_HI_I(dhi),
        .OFFTIME_STRAP_I(strap), .OFFTIME_SET_PIN_I(set_us), .CURRENT_TRIP_I(trip),
        .ZERO_CURRENT_I(zero), .OVERCURRENT_GUARD_I(overcurrent_guard), .THERMAL_CUTOFF_I(therm),
        .SUPPLY_LOW_LOCKOUT_I(supply_low_lockout), .HS_A_O(hs_a), .LS_A_O(ls_a), .HS_B_O(hs_b), .LS_B_O(ls_b),
        .REGULATION_ACTIVE_N_OUT_O(od_v[1]), .REGULATION_ACTIVE_N_OE_O(reg_oe),
        .FAULT_N_OUT_O(od_v[0]), .FAULT_N_OE_O(flt_oe), .TRIP_LEVEL_O(lvl));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t ns: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    task automatic gchk(input logic [3:0] exp);
        chk({6'h00, gates}, {6'h00, exp});
    endtask
    task automatic fchk(input logic f, input logic exp);
        chk({9'h000, f}, {9'h000, exp});
    endtask
    // Bounded so a stuck flag cannot hang the run
    task automatic hold(input logic use_flt, input logic lvl_w, input int lim);
        n = 0;
        while ((use_flt ? flt_oe : reg_oe) === lvl_w && n < lim) begin
            n++;
            cyc(1);
        end
    endtask
    task automatic set_br(input logic e, input logic x, input logic y);
        en_r <= e;
        a_r  <= x;
        b_r  <= y;
        cyc(8);
    endtask
    task automatic trip_pulse();
        trip = 1'b1;
        cyc(10);
        trip = 1'b0;
    endtask
    task wrap_up();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(5);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            set_br(i[2], i[1], i[0]);
            gchk(i[2] ? {i[1], !i[1], i[0], !i[0]} : 4'h0);
            fchk(reg_oe, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            code = 4'(i);
            cyc(4);
            chk(lvl, 10'(PM[i]));
        end
        set_br(1'b1, 1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            strap = (i == 0);
            set_us = 8'(SET_US[i]);
            cyc(300);
            trip_pulse();
            hold(1'b0, 1'b1, 9000);
            chk(10'(n + 6 >= EXP_US[i] * CPU - 2 && n + 6 <= EXP_US[i] * CPU + 2), 10'h001);
            cyc(2);
            gchk(4'h9);
        end
        strap = 1'b1;
        for (int d = 0; d < 4; d++) begin
            {dhi, dlo} = 2'(d);
            cyc(300);
            trip_pulse();
            fchk(reg_oe, 1'b1);
            gchk(d == 0 ? 4'h5 : 4'h6);
            if (d == 1 || d == 2) begin
                cyc(d * 600 + 90);
                gchk(4'h5);
            end
            if (d == 3) begin
                zero = 1'b1;
                cyc(6);
                gchk(4'h0);
                zero = 1'b0;
            end
            hold(1'b0, 1'b1, 3000);
        end
        {dhi, dlo} = 2'h0;
        set_br(1'b1, 1'b1, 1'b1);
        set_br(1'b1, 1'b1, 1'b0);
        trip_pulse();
        cyc(6);
        fchk(reg_oe, 1'b0);
        cyc(300);
        pwm <= 1'b1;
        trip = 1'b1;
        hold(1'b0, 1'b0, 800);
        fchk(reg_oe, 1'b1);
        hold(1'b0, 1'b1, 3000);
        chk(10'(n < 300), 10'h001);
        trip = 1'b0;
        pwm <= 1'b0;
        cyc(300);
        overcurrent_guard = 1'b1;
        cyc(100);
        overcurrent_guard = 1'b0;
        cyc(10);
        fchk(flt_oe, 1'b0);
        overcurrent_guard = 1'b1;
        cyc(300);
        fchk(flt_oe, 1'b1);
        gchk(4'h0);
        chk({8'h00, od_v}, 10'h000);
        cyc(550);
        fchk(flt_oe, 1'b0);
        cyc(250);
        fchk(flt_oe, 1'b1);
        overcurrent_guard = 1'b0;
        hold(1'b1, 1'b1, 1000);
        chk(10'(n > RETRY - 150 && n < RETRY - 50), 10'h001);
        cyc(6);
        gchk(4'h9);
        for (int i = 1; i < 4; i++) begin
            {therm, supply_low_lockout} = 2'(i);
            cyc(8);
            fchk(flt_oe, 1'b1);
            gchk(4'h0);
            therm = 1'b0;
            cyc(8);
            fchk(flt_oe, i != 2);
            supply_low_lockout = 1'b0;
            cyc(8);
            fchk(flt_oe, 1'b0);
            gchk(4'h9);
        end
        slp_n = 1'b0;
        cyc(8);
        gchk(4'h0);
        slp_n = 1'b1;
        cyc(8);
        gchk(4'h9);
        wrap_up();
    end
    initial begin
        cyc(80000);
        num_errors++;
        wrap_up();
    end
endmodule // hbridge_chopper_control_tb_top
